// [cmpb_builder.sv]
/*
 Mode page builder: streams selected page bytes, clipped by allocation length.
 Assumes start is a one-cycle pulse and the sink takes a byte every cycle.
*/
`timescale 1ns/1ps
// What this block does
// - geometry page savable bit is zero
// - geometry page code 1E in bits 5..0
// - geometry byte 1 reports two following bytes
// - geometry member index and rotate read zero
// - capabilities page savable bit is zero
// - capabilities page code is 1F
// - capabilities byte 1 reports 12 hex
// - all four storage capable bits read one
// - move bits one except handler-handler, port-port
// - all exchange capability bits read zero
// - display page savable bit is one
// - display page code is 22
// - display byte 1 reports 52 hex
// - per-line flags show host-written text
// - four 20-char panel lines in order
// - stop at smaller of data, allocation
module cmpb_builder
   import cmpb_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // request
   input wire logic start,
   input wire cmpb_req_t req,
   // panel contents
   input wire logic [3:0] lineFromHost,
   input wire logic [LINES*LINE_CHARS*8-1:0] panelText,
   // byte stream
   output cmpb_beat_t beat,
   output logic busy,
   output logic badPage
);
   typedef enum logic [1:0] {CMPB_IDLE, CMPB_SEND, CMPB_DONE} cmpb_state_t;

   cmpb_state_t state, next_state;
   cmpb_page_t page, next_page;
   logic allPages, next_allPages;
   logic [7:0] index, next_index;
   logic [15:0] remain, next_remain;
   logic next_busy, next_badPage;
   logic emitting, next_emitting;
   logic lastSent, next_lastSent;
   logic [7:0] pageByte;
   logic [7:0] pageEnd;
   logic pageFinal;
   logic streamFinal;
   logic codeOk;
   logic [7:0] romIndex;

   // =====================================================
   // byte source; index parked out of range outside a transfer so the rom register clears
   assign romIndex = (state == CMPB_SEND) ? index : OFS_NONE;
   cmpb_page_rom u_rom (
      .clk(clk),
      .arst_n(arst_n),
      .page(page),
      .index(romIndex),
      .lineFromHost(lineFromHost),
      .panelText(panelText),
      .pageByte(pageByte)
   );

   // =====================================================
   // sequencing
   always_comb begin
      case (page)
         CMPB_GEOM: pageEnd = LEN_GEOM + HDR_BYTES - ONE_8;
         CMPB_CAPS: pageEnd = LEN_CAPS + HDR_BYTES - ONE_8;
         CMPB_DISP: pageEnd = LEN_DISP + HDR_BYTES - ONE_8;
         default: pageEnd = ZERO_BYTE;
      endcase
      pageFinal = (index == pageEnd);
      streamFinal = (remain == ONE_16) || (pageFinal && (!allPages || page == CMPB_DISP));
      codeOk = (req.pageCode == PC_GEOM) || (req.pageCode == PC_CAPS) ||
               (req.pageCode == PC_DISP) || (req.pageCode == PC_ALL);
      next_state = state;
      next_page = page;
      next_allPages = allPages;
      next_index = index;
      next_remain = remain;
      next_busy = busy;
      next_badPage = badPage;
      next_emitting = 1'b0;
      next_lastSent = 1'b0;
      case (state)
         CMPB_IDLE: begin
            if (start) begin
               next_badPage = !codeOk;
               next_index = ZERO_BYTE;
               next_remain = req.allocLen;
               next_allPages = (req.pageCode == PC_ALL);
               case (req.pageCode)
                  PC_CAPS: next_page = CMPB_CAPS;
                  PC_DISP: next_page = CMPB_DISP;
                  default: next_page = CMPB_GEOM; // 3F starts at lowest code
               endcase
               if (codeOk && req.allocLen != 16'h0000) begin
                  next_state = CMPB_SEND;
                  next_busy = 1'b1;
               end
            end
         end
         CMPB_SEND: begin
            next_emitting = 1'b1;
            next_lastSent = streamFinal;
            next_remain = remain - ONE_16;
            if (streamFinal) begin
               next_state = CMPB_DONE;
            end else if (pageFinal) begin
               next_index = ZERO_BYTE;
               next_page = (page == CMPB_GEOM) ? CMPB_CAPS : CMPB_DISP;
            end else begin
               next_index = index + ONE_8;
            end
         end
         CMPB_DONE: begin
            next_state = CMPB_IDLE;
            next_busy = 1'b0;
         end
         default: next_state = CMPB_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= CMPB_IDLE;
         page <= CMPB_GEOM;
         allPages <= 1'b0;
         index <= ZERO_BYTE;
         remain <= 16'h0000;
         busy <= 1'b0;
         badPage <= 1'b0;
         emitting <= 1'b0;
         lastSent <= 1'b0;
      end else begin
         state <= next_state;
         page <= next_page;
         allPages <= next_allPages;
         index <= next_index;
         remain <= next_remain;
         busy <= next_busy;
         badPage <= next_badPage;
         emitting <= next_emitting;
         lastSent <= next_lastSent;
      end
   end

   // =====================================================
   // stream output: rom byte is registered alongside the flags
   always_comb begin
      beat.valid = emitting;
      beat.data = pageByte;
      beat.last = lastSent;
   end

   // =====================================================
   // checks
   a_zero_alloc_silent: assert property (@(posedge clk) disable iff (!arst_n)
      start && !busy && req.allocLen == 16'h0000 |=> !beat.valid [*3])
      else $error("beat sent for zero allocation");

   sequence s_start_geom;
      start && !busy && req.pageCode == PC_GEOM && req.allocLen > 16'h0003;
   endsequence
   a_geom_header: assert property (@(posedge clk) disable iff (!arst_n)
      s_start_geom |-> ##2 beat.valid && beat.data == 8'h1E ##1 beat.data == 8'h02)
      else $error("geometry header wrong");

   a_geom_tail: assert property (@(posedge clk) disable iff (!arst_n)
      s_start_geom |-> ##4 beat.data == 8'h00 ##1 beat.data == 8'h00 && beat.last)
      else $error("geometry tail wrong");

   sequence s_start_caps;
      start && !busy && req.pageCode == PC_CAPS && req.allocLen > 16'h0014;
   endsequence
   a_caps_header: assert property (@(posedge clk) disable iff (!arst_n)
      s_start_caps |-> ##2 beat.data == 8'h1F ##1 beat.data == 8'h12 ##1 beat.data == 8'h0F)
      else $error("capabilities header wrong");

   a_caps_moves: assert property (@(posedge clk) disable iff (!arst_n)
      s_start_caps |-> ##6 beat.data == 8'h0E ##1 beat.data == 8'h0F ##1 beat.data == 8'h0B
         ##1 beat.data == 8'h0F)
      else $error("move capability bytes wrong");

   a_caps_exchange: assert property (@(posedge clk) disable iff (!arst_n)
      s_start_caps |-> ##14 beat.valid && beat.data == 8'h00 [*4] ##4 beat.last)
      else $error("exchange capability bytes wrong");

   a_disp_header: assert property (@(posedge clk) disable iff (!arst_n)
      start && !busy && req.pageCode == PC_DISP && req.allocLen > 16'h0054
      |-> ##2 beat.data == 8'hA2 ##1 beat.data == 8'h52)
      else $error("display header wrong");

   a_disp_flags: assert property (@(posedge clk) disable iff (!arst_n)
      start && !busy && req.pageCode == PC_DISP && req.allocLen > 16'h0054
      |-> ##4 beat.data == {4'h0, $past(lineFromHost)})
      else $error("display line flags wrong");

   a_all_chain: assert property (@(posedge clk) disable iff (!arst_n)
      start && !busy && req.pageCode == PC_ALL && req.allocLen > 16'h0005
      |-> ##5 beat.data == 8'h00 && !beat.last ##1 beat.data == 8'h1F)
      else $error("page chain for all pages wrong");

   a_alloc_one: assert property (@(posedge clk) disable iff (!arst_n)
      start && !busy && codeOk && req.allocLen == 16'h0001
      |-> ##2 beat.valid && beat.last ##1 !beat.valid)
      else $error("single byte clip wrong");

   a_bad_code: assert property (@(posedge clk) disable iff (!arst_n)
      start && !busy && !codeOk |=> badPage && !busy [*2])
      else $error("bad page code not flagged");

   a_valid_busy: assert property (@(posedge clk) disable iff (!arst_n)
      beat.valid |-> busy && $past(state) == CMPB_SEND)
      else $error("beat outside transfer");
endmodule : cmpb_builder

// [cmpb_host_model.sv]
/*
 Host model: issues page requests to the builder as one-cycle pulses.
 Assumes the bench calls send only while the builder is idle.
*/
`timescale 1ns/1ps
module cmpb_host_model
   import cmpb_pkg::*;
(
   // clock
   input wire logic clk,
   // request
   output logic start,
   output cmpb_req_t req
);
   // idle request lines
   initial begin
      start = 1'b0;
      req = '0;
   end
   // one-cycle request, driven just after an edge
   task automatic send(input logic [5:0] code, input logic [15:0] len);
      @(posedge clk);
      #2;
      req.pageCode = code;
      req.allocLen = len;
      start = 1'b1;
      @(posedge clk);
      #2;
      start = 1'b0;
   endtask : send
endmodule : cmpb_host_model

// [cmpb_page_rom.sv]
/*
 Byte generator for one mode page: registered byte at an index.
 Assumes the panel text and override flags are held steady by the user.
*/
`timescale 1ns/1ps
module cmpb_page_rom
   import cmpb_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // selection
   input wire cmpb_page_t page,
   input wire logic [7:0] index,
   // panel contents
   input wire logic [3:0] lineFromHost,
   input wire logic [LINES*LINE_CHARS*8-1:0] panelText,
   // registered byte
   output logic [7:0] pageByte
);
   logic [7:0] next_pageByte;
   logic [7:0] textIdx;

   // =====================================================
   // byte selection
   always_comb begin
      next_pageByte = ZERO_BYTE;
      textIdx = index - 8'(TEXT_START);
      case (page)
         CMPB_GEOM: begin
            case (index)
               OFS_CODE: next_pageByte = {SAVE_GEOM, 1'b0, PC_GEOM};
               OFS_LEN: next_pageByte = LEN_GEOM;
               default: next_pageByte = ZERO_BYTE;
            endcase
         end
         CMPB_CAPS: begin
            case (index)
               OFS_CODE: next_pageByte = {SAVE_CAPS, 1'b0, PC_CAPS};
               OFS_LEN: next_pageByte = LEN_CAPS;
               OFS_FLAGS: next_pageByte = CAP_STORE;
               OFS_MOVE_HANDLER: next_pageByte = MOVE_HANDLER;
               OFS_MOVE_SLOT: next_pageByte = MOVE_SLOT;
               OFS_MOVE_PORT: next_pageByte = MOVE_PORT;
               OFS_MOVE_DRIVE: next_pageByte = MOVE_DRIVE;
               default: next_pageByte = ZERO_BYTE;
            endcase
         end
         CMPB_DISP: begin
            case (index)
               OFS_CODE: next_pageByte = {SAVE_DISP, 1'b0, PC_DISP};
               OFS_LEN: next_pageByte = LEN_DISP;
               OFS_FLAGS: next_pageByte = {4'h0, lineFromHost};
               OFS_RSVD: next_pageByte = ZERO_BYTE;
               default: begin
                  // line 1 first char sits at the top of the vector
                  if (textIdx < 8'(LINES*LINE_CHARS)) begin
                     next_pageByte = panelText[(LINES*LINE_CHARS-1-int'(textIdx))*8 +: 8];
                  end
               end
            endcase
         end
         default: next_pageByte = ZERO_BYTE;
      endcase
   end

   // output register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pageByte <= ZERO_BYTE;
      end else begin
         pageByte <= next_pageByte;
      end
   end
endmodule : cmpb_page_rom

// [cmpb_pkg.sv]
/*
 Constants and carrier types for the changer mode page builder.
 Assumes a single 40 MHz clock domain; no registers, plain ports only.
*/
package cmpb_pkg;
   // =====================================================
   // page codes
   localparam logic [5:0] PC_GEOM = 6'h1E;
   localparam logic [5:0] PC_CAPS = 6'h1F;
   localparam logic [5:0] PC_DISP = 6'h22;
   localparam logic [5:0] PC_ALL = 6'h3F;
   // =====================================================
   // lengths
   localparam logic [7:0] LEN_GEOM = 8'h02;
   localparam logic [7:0] LEN_CAPS = 8'h12;
   localparam logic [7:0] LEN_DISP = 8'h52;
   localparam logic [7:0] HDR_BYTES = 8'h02;
   localparam int LINE_CHARS = 20;
   localparam int LINES = 4;
   localparam int TEXT_START = 4;
   // =====================================================
   // fixed byte values
   localparam logic SAVE_GEOM = 1'b0;
   localparam logic SAVE_CAPS = 1'b0;
   localparam logic SAVE_DISP = 1'b1;
   localparam logic [7:0] CAP_STORE = 8'h0F;
   localparam logic [7:0] MOVE_HANDLER = 8'h0E;
   localparam logic [7:0] MOVE_SLOT = 8'h0F;
   localparam logic [7:0] MOVE_PORT = 8'h0B;
   localparam logic [7:0] MOVE_DRIVE = 8'h0F;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [15:0] ONE_16 = 16'h0001;
   localparam logic [7:0] ONE_8 = 8'h01;
   // =====================================================
   // byte offsets within a page
   localparam logic [7:0] OFS_CODE = 8'h00;
   localparam logic [7:0] OFS_LEN = 8'h01;
   localparam logic [7:0] OFS_FLAGS = 8'h02;
   localparam logic [7:0] OFS_RSVD = 8'h03;
   localparam logic [7:0] OFS_MOVE_HANDLER = 8'h04;
   localparam logic [7:0] OFS_MOVE_SLOT = 8'h05;
   localparam logic [7:0] OFS_MOVE_PORT = 8'h06;
   localparam logic [7:0] OFS_MOVE_DRIVE = 8'h07;
   localparam logic [7:0] OFS_NONE = 8'hFF;
   // =====================================================
   // types
   typedef enum logic [1:0] {CMPB_GEOM, CMPB_CAPS, CMPB_DISP} cmpb_page_t;
   typedef struct packed {
      logic [5:0] pageCode;
      logic [15:0] allocLen;
   } cmpb_req_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
   } cmpb_beat_t;
endpackage : cmpb_pkg

// [tb_top.sv]
/*
 Testbench: page requests, expected byte queue, stream monitor.
 Assumes the builder and host model files are compiled first.
*/
`timescale 1ns/1ps
module tb_top
   import cmpb_pkg::*;
;
   localparam logic [5:0] CODES [0:3] = '{6'h1E, 6'h1F, 6'h22, 6'h3F};
   localparam logic [7:0] CAPB [0:7] = '{8'h1F, 8'h12, 8'h0F, 8'h00,
                                         8'h0E, 8'h0F, 8'h0B, 8'h0F};
   logic clk;
   logic arst_n;
   logic start;
   cmpb_req_t req;
   logic [3:0] lineFromHost;
   logic [639:0] panelText;
   cmpb_beat_t beat;
   logic busy;
   logic badPage;
   logic [31:0] seed;
   logic [8:0] expQ[$];
   int errors;
   int n_compared;
   int cyc;

   cmpb_builder DUT (.clk(clk), .arst_n(arst_n), .start(start), .req(req),
      .lineFromHost(lineFromHost), .panelText(panelText), .beat(beat),
      .busy(busy), .badPage(badPage));
   cmpb_host_model host (.clk(clk), .start(start), .req(req));

   // clock, 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // =====================================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // expected byte i of page pc
   function automatic logic [7:0] pb(input logic [5:0] pc, input int i);
      if (pc == 6'h1E)
         return (i == 0) ? 8'h1E : (i == 1) ? 8'h02 : 8'h00;
      if (pc == 6'h1F)
         return (i < 8) ? CAPB[i] : 8'h00;
      if (i < 4)
         return (i == 0) ? 8'hA2 : (i == 1) ? 8'h52 : (i == 2) ? {4'h0, lineFromHost} : 8'h00;
      return panelText[639 - 8 * (i - 4) -: 8];
   endfunction : pb

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask : chk

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   // new panel contents, then one request and its expected stream
   task automatic run(input logic [5:0] code, input logic [15:0] len);
      logic [8:0] b[$];
      logic [5:0] p;
      logic bad;
      int k;
      @(posedge clk);
      #2;
      for (int j = 0; j < 20; j++) begin
         seed = xs(seed);
         panelText[32 * j +: 32] = seed;
      end
      lineFromHost = seed[7:4];
      bad = !(code inside {6'h1E, 6'h1F, 6'h22, 6'h3F});
      for (int q = 0; q < 3; q++) begin
         p = CODES[q];
         if (code == p || code == 6'h3F)
            for (int i = 0; i < ((p == 6'h1E) ? 4 : (p == 6'h1F) ? 20 : 84); i++)
               b.push_back({1'b0, pb(p, i)});
      end
      while (b.size() > len)
         b.pop_back();
      if (b.size() > 0)
         b[b.size() - 1][8] = 1'b1;
      expQ = b;
      host.send(code, len);
      repeat (3) @(negedge clk);
      k = 0;
      while (busy === 1'b1 && k < 300) begin
         @(negedge clk);
         k++;
      end
      chk("busy", 16'h0, {15'h0, busy});
      chk("badPage", {15'h0, bad}, {15'h0, badPage});
      chk("missing", 16'h0, 16'(expQ.size()));
      repeat (2) @(posedge clk);
   endtask : run

   // =====================================================
   // monitor: each valid byte against the oldest note, away from the launching edge
   always @(negedge clk) begin
      if (beat.valid === 1'b1) begin
         if (expQ.size() == 0)
            chk("extra", 16'h0, 16'h1);
         else
            chk("beat", {7'h0, expQ.pop_front()}, {7'h0, beat.last, beat.data});
      end
   end

   // timeout guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         final_report();
      end
   end

   // main sequence
   initial begin
      arst_n = 1'b0;
      seed = 32'hA84E;
      lineFromHost = 4'h0;
      panelText = '0;
      errors = 0;
      n_compared = 0;
      cyc = 0;
      repeat (20) @(posedge clk);
      #2;
      arst_n = 1'b1;
      chk("busy", 16'h0, {15'h0, busy});
      for (int c = 0; c < 4; c++)
         run(CODES[c], 16'hFFFF);
      run(6'h22, 16'h0000);
      run(6'h3F, 16'h0001);
      run(6'h3F, 16'h0032);
      run(6'h10, 16'h0008);
      for (int r = 0; r < 6; r++) begin
         seed = xs(seed);
         run(CODES[seed[1:0]], {9'h0, seed[14:8]});
      end
      final_report();
   end
endmodule : tb_top
